// ===== logic/exec_slice_map.vh
// Purpose: Opcodes, field positions, phase codes and constants for the execution slice
// Assumes: 16-bit instruction words, 8-bit data path
// Notes:   Definitions only
`ifndef EXEC_SLICE_MAP_VH
`define EXEC_SLICE_MAP_VH

// Upper-byte opcode patterns (d bit at position 8 masked where present)
`define OP_INC_REG        8'h14
`define OP_INC_SKIP_Z     8'h1E
`define OP_INC_SKIP_NZ    8'h24
`define OP_OR_LIT         8'hB3
`define OP_OR_REG         8'h08
`define OP_LONG_CALL      8'hB7
`define OP_COPY_PERIPH    3'h3
`define OP_MASK_D         8'hFE

// Field positions
`define HI_MSB            15
`define HI_LSB            8
`define LO_MSB            7
`define LO_LSB            0
`define D_BIT             8
`define P_MSB             12
`define P_LSB             8
`define TOP3_MSB          15
`define TOP3_LSB          13

// Phase codes, one instruction cycle spans all four
`define PH_DECODE         2'h0
`define PH_READ           2'h1
`define PH_PROCESS        2'h2
`define PH_WRITE          2'h3

// Status vector layout
`define ST_CARRY          0
`define ST_NIBBLE         1
`define ST_ZERO           2
`define ST_SIGNED         3

// Constants
`define BYTE_ZERO         8'h00
`define BYTE_ONE          8'h01
`define WORD_ONE          16'h0001
`define NIB_ONE           5'h01
`define ACC_ADDR          8'h0A
`define PERIPH_PAD        3'h0
`define STATUS_RESET      4'h0

`endif

// ===== logic/phase_counter.v
// Purpose: Four-phase sequencer for one instruction cycle
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Wraps from write phase back to decode
`timescale 1ns/10ps
`include "exec_slice_map.vh"

module phase_counter (
  // Clock and reset
  input  wire       clk_in,
  input  wire       reset_in,
  // Phase
  output reg  [1:0] phase_out,
  output wire       last_out
);

  assign last_out = (phase_out == `PH_WRITE);

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_out <= `PH_DECODE;
    end else begin
      phase_out <= phase_out + 2'h1;
    end
  end

endmodule

// ===== logic/incr_or_call_move_exec.v
// Purpose: Executes increment, OR, long call and copy-to-peripheral instructions
// Assumes: Memory read data valid in the same clock as the read strobe
// Notes:   Other opcodes pass as no-ops; the core handles them elsewhere
`timescale 1ns/10ps
`include "exec_slice_map.vh"

// Contract
// - increment_reg adds one to f, writes acc or f, updates four flags.
// - increment_skip_zero writes result, keeps flags, flushes next word on zero.
// - increment_skip_nonzero writes result, keeps flags, flushes next on non-zero.
// - or_literal_acc ORs literal into accumulator and sets zero flag, one cycle.
// - or_acc_reg ORs accumulator with f into acc or f, sets zero flag.
// - Long call pushes program counter plus one before loading target.
// - Call target is latch byte high and literal byte low.
// - Long call takes two cycles, second is idle, flags untouched.
// - Copy f into peripheral p in one cycle, no flags changed.
// - Accumulator selected as source or destination behaves as ordinary register.
// - Both copy operands may resolve through indirect addressing.
module incr_or_call_move_exec (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // Fetched instruction and program counter
  input  wire [15:0] instr_in,
  input  wire [15:0] pc_in,
  input  wire [7:0]  upper_pc_holding_latch_in,
  // Indirect address resolution from the core
  input  wire        src_indirect_in,
  input  wire [7:0]  src_indirect_addr_in,
  input  wire        dst_indirect_in,
  input  wire [7:0]  dst_indirect_addr_in,
  // Data memory
  output reg  [7:0]  mem_addr_out,
  output reg         mem_read_out,
  output reg         mem_write_out,
  output reg  [7:0]  mem_wdata_out,
  input  wire [7:0]  mem_rdata_in,
  // Accumulator and flags
  input  wire [7:0]  working_accumulator_in,
  output reg         acc_write_out,
  output reg  [7:0]  acc_wdata_out,
  output reg  [3:0]  status_out,
  // Program counter and stack
  output reg         stack_push_out,
  output reg  [15:0] stack_top_entry_out,
  output reg         pc_load_out,
  output reg  [15:0] pc_target_out,
  // Sequencing
  output wire [1:0]  phase_out,
  output reg         flush_out,
  output wire        cycle_end_out
);

  wire [1:0] phase;
  wire       last;
  reg        skip_cycle;
  reg  [7:0] opr_a;
  reg  [7:0] result;
  reg        res_c;
  reg        res_dc;
  reg        res_ov;
  reg  [7:0] dst_addr;
  reg        dst_acc;
  reg  [7:0] next_opr;
  reg  [7:0] next_dst_addr;
  reg        next_dst_acc;
  reg  [3:0] next_status;
  reg        take_skip;
  // Write-phase decisions
  reg        next_flush;
  reg        next_mem_write;
  reg        next_acc_write;
  reg        next_arith_flags;
  reg        next_zero_flag;
  reg        next_call;

  wire [7:0] hi       = instr_in[`HI_MSB:`HI_LSB];
  wire [7:0] lo       = instr_in[`LO_MSB:`LO_LSB];
  wire [7:0] hi_nod   = hi & `OP_MASK_D;
  wire       d_bit    = instr_in[`D_BIT];
  wire       is_inc   = (hi_nod == `OP_INC_REG);
  wire       is_isz   = (hi_nod == `OP_INC_SKIP_Z);
  wire       is_isnz  = (hi_nod == `OP_INC_SKIP_NZ);
  wire       is_orl   = (hi == `OP_OR_LIT);
  wire       is_orr   = (hi_nod == `OP_OR_REG);
  wire       is_call  = (hi == `OP_LONG_CALL);
  wire       is_copy  = (instr_in[`TOP3_MSB:`TOP3_LSB] == `OP_COPY_PERIPH);
  wire       any_inc  = is_inc | is_isz | is_isnz;
  wire       reads_f  = any_inc | is_orr | is_copy;
  wire [7:0] src_addr = src_indirect_in ? src_indirect_addr_in : lo;
  wire [7:0] p_addr   = {`PERIPH_PAD, instr_in[`P_MSB:`P_LSB]};
  wire [8:0] inc_sum  = {1'b0, opr_a} + {1'b0, `BYTE_ONE};
  wire [4:0] nib_sum  = {1'b0, opr_a[3:0]} + `NIB_ONE;
  wire       src_is_acc  = is_copy & ~src_indirect_in & (lo == `ACC_ADDR);
  wire       result_zero = (result == `BYTE_ZERO);
  // Phase strobes; a flushed cycle clears live for all four phases
  wire       in_decode   = (phase == `PH_DECODE);
  wire       in_process  = (phase == `PH_PROCESS);
  wire       in_write    = (phase == `PH_WRITE);
  wire       live        = ~skip_cycle;

  phase_counter u_phase (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .phase_out (phase),
    .last_out  (last)
  );

  assign phase_out     = phase;
  assign cycle_end_out = last;

  // Process-phase arithmetic, combinational from the captured operand
  always @* begin
    result = opr_a;
    res_c  = 1'b0;
    res_dc = 1'b0;
    res_ov = 1'b0;
    if (any_inc) begin
      result = inc_sum[7:0];
      res_c  = inc_sum[8];
      res_dc = nib_sum[4];
      res_ov = ~opr_a[7] & inc_sum[7]; // Only 7F to 80 overflows
    end else if (is_orl) begin
      result = working_accumulator_in | lo;
    end else if (is_orr) begin
      result = working_accumulator_in | opr_a;
    end
  end

  // Source operand: the accumulator is read live, memory holds no copy of it
  always @* begin
    next_opr = mem_rdata_in;
    if (src_is_acc) begin
      next_opr = working_accumulator_in;
    end
  end

  // Destination chosen at decode; a copy may land in the accumulator or an indirect target
  always @* begin
    next_dst_addr = src_addr;
    next_dst_acc  = ~d_bit;
    if (is_copy) begin
      if (dst_indirect_in) begin
        next_dst_addr = dst_indirect_addr_in;
        next_dst_acc  = 1'b0;
      end else begin
        next_dst_addr = p_addr;
        next_dst_acc  = (p_addr == `ACC_ADDR);
      end
    end
  end

  // Skip is judged on the value being written, not on the operand read
  always @* begin
    take_skip = 1'b0;
    if (is_isz) begin
      take_skip = result_zero;
    end
    if (is_isnz) begin
      take_skip = ~result_zero;
    end
  end

  // Write-phase decisions; a flushed cycle forces every one of them low
  always @* begin
    next_mem_write   = 1'b0;
    next_acc_write   = 1'b0;
    next_arith_flags = 1'b0;
    next_zero_flag   = 1'b0;
    next_call        = 1'b0;
    next_flush       = 1'b0;
    if (live) begin
      if (any_inc || is_orr || is_copy) begin
        next_mem_write = ~dst_acc;
        next_acc_write = dst_acc;
      end
      if (is_orl) begin
        next_acc_write = 1'b1;
      end
      if (is_inc) begin
        next_arith_flags = 1'b1;
      end
      if (is_inc || is_orl || is_orr) begin
        next_zero_flag = 1'b1;
      end
      if (is_call) begin
        next_call  = 1'b1;
        next_flush = 1'b1;
      end
      if (take_skip) begin
        next_flush = 1'b1;
      end
    end
  end

  // Next flag vector; only the write phase of a live cycle may move it
  always @* begin
    next_status = status_out;
    if (in_write && next_arith_flags) begin
      next_status[`ST_CARRY]  = res_c;
      next_status[`ST_NIBBLE] = res_dc;
      next_status[`ST_SIGNED] = res_ov;
    end
    if (in_write && next_zero_flag) begin
      next_status[`ST_ZERO] = result_zero;
    end
  end

  // A flush spans the four phases after the decision, so the core sees one idle cycle
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      skip_cycle <= 1'b0;
      flush_out  <= 1'b0;
    end else if (in_write) begin
      skip_cycle <= next_flush;
      flush_out  <= next_flush;
    end
  end

  // Operand and destination capture
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      opr_a    <= `BYTE_ZERO;
      dst_addr <= `BYTE_ZERO;
      dst_acc  <= 1'b0;
    end else begin
      case (phase)
        `PH_DECODE: begin
          dst_addr <= next_dst_addr;
          dst_acc  <= next_dst_acc;
        end
        `PH_READ: begin
          if (live) begin
            opr_a <= next_opr;
          end
        end
        default: begin
          opr_a <= opr_a;
        end
      endcase
    end
  end

  // Data memory port: read strobe in the read phase, write strobe after the write phase
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_addr_out  <= `BYTE_ZERO;
      mem_read_out  <= 1'b0;
      mem_write_out <= 1'b0;
      mem_wdata_out <= `BYTE_ZERO;
    end else begin
      mem_read_out  <= in_decode & live & reads_f;
      mem_write_out <= in_write & next_mem_write;
      if (in_decode && live && reads_f) begin
        mem_addr_out <= src_addr;
      end
      if (in_write && next_mem_write) begin
        mem_addr_out  <= dst_addr;
        mem_wdata_out <= result;
      end
    end
  end

  // Accumulator port
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      acc_write_out <= 1'b0;
      acc_wdata_out <= `BYTE_ZERO;
    end else begin
      acc_write_out <= in_write & next_acc_write;
      if (in_write && next_acc_write) begin
        acc_wdata_out <= result;
      end
    end
  end

  // Flag register
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_out <= `STATUS_RESET;
    end else begin
      status_out <= next_status;
    end
  end

  // Return address lands on the stack a phase before the target load
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stack_push_out      <= 1'b0;
      stack_top_entry_out <= `WORD_ONE;
      pc_load_out         <= 1'b0;
      pc_target_out       <= `WORD_ONE;
    end else begin
      stack_push_out <= in_process & live & is_call;
      pc_load_out    <= in_write & next_call;
      if (in_process && live && is_call) begin
        stack_top_entry_out <= pc_in + `WORD_ONE;
      end
      if (in_write && next_call) begin
        pc_target_out <= {upper_pc_holding_latch_in, lo};
      end
    end
  end

endmodule

// ===== verification/exec_checker.sv
// Purpose: Port-level timing checks for the execution slice
// Assumes: Single clock, reset_in asynchronous active high
// Notes:   Phase relations plus call return address and target; other values are judged by the bench
`timescale 1ns/10ps
module exec_checker (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic [15:0] instr_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0]  upper_pc_holding_latch_in,
  input wire logic        mem_read_out,
  input wire logic        mem_write_out,
  input wire logic        acc_write_out,
  input wire logic [3:0]  status_out,
  input wire logic        stack_push_out,
  input wire logic [15:0] stack_top_entry_out,
  input wire logic        pc_load_out,
  input wire logic [15:0] pc_target_out,
  input wire logic [1:0]  phase_out,
  input wire logic        flush_out,
  input wire logic        cycle_end_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_push;
    stack_push_out && phase_out == 2'h3;
  endsequence
  sequence s_load;
    pc_load_out && flush_out && phase_out == 2'h0;
  endsequence
  chk_read_phase: assert property (mem_read_out |-> phase_out == 2'h1)
    else $error("read strobe outside phase 1");
  chk_write_phase: assert property ((mem_write_out || acc_write_out) |-> phase_out == 2'h0)
    else $error("write outside phase 0");
  chk_call_order: assert property (s_push |=> s_load)
    else $error("push not followed by load");
  chk_return_addr: assert property (stack_push_out |-> stack_top_entry_out == pc_in + 16'h0001)
    else $error("bad return address");
  chk_call_target: assert property (pc_load_out |->
    pc_target_out == {$past(upper_pc_holding_latch_in), $past(instr_in[7:0])})
    else $error("bad call target");
  chk_flush_len: assert property ($rose(flush_out) |-> flush_out [*4] ##1 !flush_out)
    else $error("flushed cycle not four phases");
  chk_flush_quiet: assert property ((flush_out && phase_out != 2'h0) |->
    !mem_read_out && !stack_push_out)
    else $error("activity in flushed cycle");
  chk_flush_nowrite: assert property ($fell(flush_out) |->
    !mem_write_out && !acc_write_out && !pc_load_out)
    else $error("write after flushed cycle");
  chk_status_time: assert property (!$stable(status_out) |-> phase_out == 2'h0)
    else $error("flags changed outside phase 0");
  chk_phase_wrap: assert property (phase_out == 2'h3 |=> phase_out == 2'h0 && !cycle_end_out)
    else $error("phase did not wrap");
endmodule
bind incr_or_call_move_exec exec_checker chk_i (.clk_in(clk_in), .reset_in(reset_in),
  .instr_in(instr_in), .pc_in(pc_in), .upper_pc_holding_latch_in(upper_pc_holding_latch_in),
  .mem_read_out(mem_read_out), .mem_write_out(mem_write_out), .acc_write_out(acc_write_out),
  .status_out(status_out), .stack_push_out(stack_push_out),
  .stack_top_entry_out(stack_top_entry_out), .pc_load_out(pc_load_out),
  .pc_target_out(pc_target_out), .phase_out(phase_out), .flush_out(flush_out),
  .cycle_end_out(cycle_end_out));

// ===== verification/tb.sv
// Purpose: Self-checking bench for the execution slice
// Assumes: Inputs change 5 ns after the rising edge
// Notes:   Results of a cycle are judged in phase 0 of the next one
`timescale 1ns/10ps
module tb;
  logic        clk_in, reset_in, si, di, r1, p3;
  logic [15:0] instr, pc, t3;
  logic [7:0]  latch, sa, da, rdata, acc, a1;
  logic [3:0]  s0;
  logic [2:0]  e3;
  wire  [7:0]  ma, wd, aw;
  wire         rd, wr, accw, push, load, fl, ce;
  wire  [3:0]  st;
  wire  [15:0] top, tgt;
  wire  [1:0]  ph;
  int          fails, n_checks;
  incr_or_call_move_exec dut (.clk_in(clk_in), .reset_in(reset_in), .instr_in(instr),
    .pc_in(pc), .upper_pc_holding_latch_in(latch), .src_indirect_in(si),
    .src_indirect_addr_in(sa), .dst_indirect_in(di), .dst_indirect_addr_in(da),
    .mem_addr_out(ma), .mem_read_out(rd), .mem_write_out(wr), .mem_wdata_out(wd),
    .mem_rdata_in(rdata), .working_accumulator_in(acc), .acc_write_out(accw),
    .acc_wdata_out(aw), .status_out(st), .stack_push_out(push), .stack_top_entry_out(top),
    .pc_load_out(load), .pc_target_out(tgt), .phase_out(ph), .flush_out(fl),
    .cycle_end_out(ce));
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  task end_sim;
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clk_in);
    #5;
  endtask
  // Runs one instruction cycle, capturing the read and push phases on the way
  task exec(input logic [15:0] i, input logic [7:0] d);
    int n;
    n = 0;
    while (ph !== 2'h0 && n < 8) begin
      tick;
      n++;
    end
    if (n == 8) begin
      fails++;
      end_sim;
    end
    s0 = st;
    instr = i;
    rdata = d;
    tick;
    r1 = rd;
    a1 = ma;
    tick;
    tick;
    p3 = push;
    t3 = top;
    e3 = {ce, ph};
    tick;
  endtask
  task t_inc;
    exec(16'h1520, 8'hFF);
    chk({wr, ma, wd, st}, {1'h1, 8'h20, 8'h00, 4'h7});
    chk({r1, a1}, {1'h1, 8'h20});
    chk(e3, 3'h7);
    chk({ce, ph}, 3'h0);
    exec(16'h1430, 8'h7F);
    chk({accw, aw, st}, {1'h1, 8'h80, 4'hA});
  endtask
  task t_skip;
    exec(16'h1F20, 8'hFF);
    chk({wr, wd, st, fl}, {1'h1, 8'h00, s0, 1'h1});
    exec(16'hB335, 8'h00);
    chk({accw, wr, r1}, 3'h0);
    exec(16'h2430, 8'h10);
    chk({accw, aw, st, fl}, {1'h1, 8'h11, s0, 1'h1});
    exec(16'h0940, 8'h00);
    chk({wr, accw}, 2'h0);
    exec(16'h2430, 8'hFF);
    chk({accw, aw, fl}, {1'h1, 8'h00, 1'h0});
    exec(16'h1E20, 8'h05);
    chk({accw, aw, fl, st}, {1'h1, 8'h06, 1'h0, s0});
  endtask
  task t_or;
    acc = 8'h9A;
    exec(16'hB335, 8'h00);
    chk({accw, aw, st[2]}, {1'h1, 8'hBF, 1'h0});
    acc = 8'h00;
    exec(16'h0940, 8'h00);
    chk({wr, ma, wd, st[2]}, {1'h1, 8'h40, 8'h00, 1'h1});
    acc = 8'h91;
    exec(16'h0840, 8'h13);
    chk({accw, aw, st[2]}, {1'h1, 8'h93, 1'h0});
  endtask
  task t_call;
    pc = 16'h1234;
    latch = 8'h56;
    exec(16'hB734, 8'h00);
    chk({p3, t3}, {1'h1, 16'h1235});
    chk({load, tgt, fl, st}, {1'h1, 16'h5634, 1'h1, s0});
    exec(16'hB335, 8'h00);
    chk({accw, load, r1}, 3'h0);
  endtask
  task t_copy;
    exec(16'h6540, 8'h77);
    chk({wr, ma, wd, st}, {1'h1, 8'h05, 8'h77, s0});
    acc = 8'h3C;
    exec(16'h650A, 8'h00);
    chk({wr, wd}, {1'h1, 8'h3C});
    exec(16'h6A40, 8'h44);
    chk({accw, aw, wr}, {1'h1, 8'h44, 1'h0});
    si = 1'h1;
    di = 1'h1;
    sa = 8'h81;
    da = 8'h90;
    exec(16'h6540, 8'h5A);
    chk({a1, ma, wd}, {8'h81, 8'h90, 8'h5A});
  endtask
  initial begin
    {reset_in, si, di, r1, p3} = 5'h10;
    {instr, pc, t3, latch, sa, da, rdata, acc, a1, s0} = 0;
    fails = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_in);
    #5 reset_in = 1'h0;
    t_inc;
    t_skip;
    t_or;
    t_call;
    t_copy;
    end_sim;
  end
endmodule
